// ---- hw/boim_alu.v ----
// Combinational result and zero-flag unit for the file/literal operations
`timescale 1ns/1ps
`include "boim_exec_regs.vh"

module boim_alu (
	input  wire [`BOIM_OP_W-1:0] i_op,
	input  wire [7:0]            i_acc,
	input  wire [7:0]            i_file,
	input  wire [7:0]            i_literal,
	output reg  [7:0]            o_result,
	output reg                   o_affects_z,
	output wire                  o_zero
);

	always @* begin
		o_affects_z = 1'b1;
		case (i_op)
		`BOIM_OP_ORLIT: o_result = i_acc | i_literal;
		`BOIM_OP_INC:   o_result = i_file + 8'h01;
		`BOIM_OP_ORWF:  o_result = i_acc | i_file;
		`BOIM_OP_MOVE:  o_result = i_file;
		default: begin
			// Jump and idle leave the flags alone
			o_result    = 8'h00;
			o_affects_z = 1'b0;
		end
		endcase
	end

	assign o_zero = (o_result == 8'h00);

endmodule

// ---- hw/boim_exec.v ----
// Execution unit for absolute jump, OR, increment and move-file operations
`timescale 1ns/1ps
`include "boim_exec_regs.vh"

module boim_exec (
	input  wire                     i_clock,
	input  wire                     i_rst,
	input  wire                     i_valid,
	input  wire [`BOIM_OP_W-1:0]    i_op,
	input  wire [`BOIM_IMM_W-1:0]   i_imm,
	input  wire [`BOIM_FADDR_W-1:0] i_faddr,
	input  wire                     i_dest,
	input  wire [7:0]               i_file_data,
	input  wire [7:0]               i_pc_high_latch,
	output reg  [`BOIM_PC_W-1:0]    o_pc,
	output reg                      o_pc_load,
	output reg  [7:0]               o_acc,
	output reg                      o_zero,
	output reg                      o_file_we,
	output reg  [`BOIM_FADDR_W-1:0] o_file_addr,
	output reg  [7:0]               o_file_wdata,
	output reg                      o_busy,
	output reg                      o_done
);

	// =================================================================
	// Sequencer states
	// Only the jump needs a second cycle; every other operation
	// finishes on the edge after it is taken.
	localparam ST_IDLE = 1'h0;
	localparam ST_JUMP = 1'h1;

	// =================================================================
	// Operation decode
	// Each test is used in one place only, but it lives here
	// rather than as an inline comparison, so the decode stays together.
	function is_jump;
		input [`BOIM_OP_W-1:0] op;
		begin
			is_jump = (op == `BOIM_OP_JUMP);
		end
	endfunction

	// Codes 6 and 7 are unused and fall through as idle slots
	function is_alu_op;
		input [`BOIM_OP_W-1:0] op;
		begin
			is_alu_op = (op == `BOIM_OP_ORLIT) ||
				(op == `BOIM_OP_INC) ||
				(op == `BOIM_OP_ORWF) ||
				(op == `BOIM_OP_MOVE);
		end
	endfunction

	// Literal OR always lands in the working register
	function to_acc;
		input [`BOIM_OP_W-1:0] op;
		input                  dest;
		begin
			to_acc = (op == `BOIM_OP_ORLIT) || !dest;
		end
	endfunction

	// File operations with the selector set write back to the file
	function to_file;
		input [`BOIM_OP_W-1:0] op;
		input                  dest;
		begin
			to_file = (op != `BOIM_OP_ORLIT) && dest;
		end
	endfunction

	// =================================================================
	// Internal state and next values
	// All next values settle combinationally and land on one edge
	reg                      state_r;
	reg                      state_nxt;
	reg  [1:0]               cyc_r;
	reg  [1:0]               cyc_nxt;
	reg  [`BOIM_PC_W-1:0]    pc_nxt;
	reg                      pc_load_nxt;
	reg  [7:0]               acc_nxt;
	reg                      zero_nxt;
	reg                      file_we_nxt;
	reg  [`BOIM_FADDR_W-1:0] file_addr_nxt;
	reg  [7:0]               file_wdata_nxt;
	reg                      busy_nxt;
	reg                      done_nxt;
	wire [7:0]               result;
	wire                     affects_z;
	wire                     result_zero;
	wire                     take;
	wire                     take_jump;
	wire                     take_alu;

	// =================================================================
	// Request acceptance
	// Work is taken only when idle. A request offered while a jump
	// finishes is dropped, not queued: the caller waits for done.
	assign take      = i_valid && (state_r == ST_IDLE);
	assign take_jump = take && is_jump(i_op);
	assign take_alu  = take && is_alu_op(i_op);

	// =================================================================
	// Result unit
	boim_alu u_alu (
		.i_op        (i_op),
		.i_acc       (o_acc),
		.i_file      (i_file_data),
		.i_literal   (i_imm[7:0]),
		.o_result    (result),
		.o_affects_z (affects_z),
		.o_zero      (result_zero)
	);

	// =================================================================
	// Sequencer
	always @* begin
		case (state_r)
		ST_IDLE:
			state_nxt = take_jump ? ST_JUMP : ST_IDLE;
		ST_JUMP:
			state_nxt = (cyc_r == `BOIM_JUMP_CYCLES - 2'h1) ?
				ST_IDLE : ST_JUMP;
		default:
			state_nxt = ST_IDLE;
		endcase
	end

	// Preset to one so the count matches the jump's second cycle
	always @* begin
		if (state_r == ST_JUMP)
			cyc_nxt = cyc_r + 2'h1;
		else
			cyc_nxt = 2'h1;
	end

	// =================================================================
	// Program counter
	// Unconditional: no flag or operand is ever tested.
	always @* begin
		pc_nxt      = o_pc;
		pc_load_nxt = 1'h0;
		if (take_jump) begin
			pc_nxt[`BOIM_IMM_W-1:0] = i_imm;
			pc_nxt[`BOIM_PC_W-1:`BOIM_IMM_W] =
				i_pc_high_latch[`BOIM_LATCH_HI:`BOIM_LATCH_LO];
			pc_load_nxt = 1'h1;
		end
	end

	// =================================================================
	// Working register and zero flag
	// Jumps and idle slots leave both alone, so software can test
	// the flag after a branch.
	always @* begin
		acc_nxt  = o_acc;
		zero_nxt = o_zero;
		if (take_alu) begin
			if (affects_z)
				zero_nxt = result_zero;
			if (to_acc(i_op, i_dest))
				acc_nxt = result;
		end
	end

	// =================================================================
	// File register write-back
	// A move to itself still writes the unchanged value; dropping
	// the strobe would save nothing but add a special case.
	always @* begin
		file_we_nxt    = 1'h0;
		file_addr_nxt  = o_file_addr;
		file_wdata_nxt = o_file_wdata;
		if (take_alu && to_file(i_op, i_dest)) begin
			file_we_nxt    = 1'h1;
			file_addr_nxt  = i_faddr;
			file_wdata_nxt = result;
		end
	end

	// =================================================================
	// Completion handshake
	// Busy covers only the jump's second cycle; done marks the
	// last cycle of every accepted jump, OR, increment or move; idle slots raise no done.
	always @* begin
		busy_nxt = (state_nxt == ST_JUMP);
		done_nxt = take_alu;
		if (state_r == ST_JUMP && state_nxt == ST_IDLE)
			done_nxt = 1'h1;
	end

	// =================================================================
	// Registers
	// Reset clears everything, outputs included, so the core wakes
	// with the flag clear and no write pending.
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_r      <= ST_IDLE;
			cyc_r        <= 2'h0;
			o_pc         <= `BOIM_PC_RST;
			o_pc_load    <= 1'h0;
			o_acc        <= `BOIM_W_RST;
			o_zero       <= `BOIM_Z_RST;
			o_file_we    <= 1'h0;
			o_file_addr  <= `BOIM_FADDR_RST;
			o_file_wdata <= `BOIM_DATA_RST;
			o_busy       <= 1'h0;
			o_done       <= 1'h0;
		end else begin
			state_r      <= state_nxt;
			cyc_r        <= cyc_nxt;
			o_pc         <= pc_nxt;
			o_pc_load    <= pc_load_nxt;
			o_acc        <= acc_nxt;
			o_zero       <= zero_nxt;
			o_file_we    <= file_we_nxt;
			o_file_addr  <= file_addr_nxt;
			o_file_wdata <= file_wdata_nxt;
			o_busy       <= busy_nxt;
			o_done       <= done_nxt;
		end
	end

endmodule

// ---- hw/boim_exec_regs.vh ----
// Constants for the jump / OR / increment / move execution block
`ifndef BOIM_EXEC_REGS_VH
`define BOIM_EXEC_REGS_VH

// =====================================================================
// Operation select codes
`define BOIM_OP_W         3
`define BOIM_OP_NONE      3'h0
`define BOIM_OP_JUMP      3'h1
`define BOIM_OP_ORLIT     3'h2
`define BOIM_OP_INC       3'h3
`define BOIM_OP_ORWF      3'h4
`define BOIM_OP_MOVE      3'h5

// =====================================================================
// Widths and field positions
`define BOIM_PC_W         13
`define BOIM_IMM_W        11
`define BOIM_FADDR_W      7
`define BOIM_LATCH_HI     4
`define BOIM_LATCH_LO     3
`define BOIM_JUMP_CYCLES  2'h2

// =====================================================================
// Reset values
`define BOIM_PC_RST       13'h0000
`define BOIM_W_RST        8'h00
`define BOIM_Z_RST        1'h0
`define BOIM_FADDR_RST    7'h00
`define BOIM_DATA_RST     8'h00

`endif

// ---- verif/boim_exec_monitor.sv ----
// Port checker for the execution block
`timescale 1ns/1ps
`include "boim_exec_regs.vh"
module boim_exec_monitor (
	input wire logic		i_clock,
	input wire logic		i_rst,
	input wire logic		i_valid,
	input wire logic [2:0]	i_op,
	input wire logic [10:0]	i_imm,
	input wire logic		i_dest,
	input wire logic [7:0]	i_file_data,
	input wire logic [7:0]	i_pc_high_latch,
	input wire logic [12:0]	o_pc,
	input wire logic		o_pc_load,
	input wire logic [7:0]	o_acc,
	input wire logic		o_zero,
	input wire logic		o_file_we,
	input wire logic [7:0]	o_file_wdata,
	input wire logic		o_busy,
	input wire logic		o_done
);
	// ==========
	// Accepted requests
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	wire tk = i_valid && !o_busy;
	wire orl = tk && i_op == `BOIM_OP_ORLIT;
	wire inc = tk && i_op == `BOIM_OP_INC;
	wire orw = tk && i_op == `BOIM_OP_ORWF;
	wire mv = tk && i_op == `BOIM_OP_MOVE;
	sequence s_jump;
		tk && i_op == `BOIM_OP_JUMP;
	endsequence
	sequence s_jump_tail;
		o_busy ##1 (o_done && !o_busy);
	endsequence
	// ==========
	// Assertions
	a_jump_target: assert property (
		s_jump |=> o_pc_load && o_pc == {$past(i_pc_high_latch[4:3]), $past(i_imm)})
		else $error("jump target");
	a_jump_two: assert property (s_jump |=> s_jump_tail)
		else $error("jump length");
	a_jump_flags: assert property (s_jump |=> $stable(o_zero)[*2])
		else $error("jump flag");
	a_or_literal: assert property (
		orl |=> o_acc == ($past(o_acc) | $past(i_imm[7:0])))
		else $error("or literal");
	a_inc_file: assert property (
		inc && i_dest |=> o_file_we && o_file_wdata == $past(i_file_data) + 8'h01)
		else $error("increment");
	a_or_file: assert property (
		orw && !i_dest |=> o_acc == ($past(o_acc) | $past(i_file_data)))
		else $error("or file");
	a_move_acc: assert property (
		mv && !i_dest |=> o_done && o_acc == $past(i_file_data))
		else $error("move to acc");
	a_move_self: assert property (
		mv && i_dest |=> o_file_wdata == $past(i_file_data)
			&& o_zero == ($past(i_file_data) == 8'h00))
		else $error("move to self");
endmodule

bind boim_exec boim_exec_monitor u_mon (.*);

// ---- verif/boim_exec_tb.sv ----
// Self-checking bench for the execution block
`timescale 1ns/1ps
module boim_exec_tb;
	logic		i_clock = 0, i_rst = 1, i_valid = 0, i_dest = 0;
	logic [2:0]	i_op = 3'h0;
	logic [10:0]	i_imm = 11'h000;
	logic [7:0]	i_fd = 8'h00, i_pl = 8'h18;
	logic [6:0]	i_fa = 7'h00;
	wire [12:0]	o_pc;
	wire [6:0]	o_fa;
	wire [7:0]	o_acc, o_wd;
	wire		o_pl, o_z, o_we, o_busy, o_done;
	int		n_errors = 0, num_checks = 0, cyc = 0;
	boim_exec u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_valid(i_valid),
		.i_op(i_op), .i_imm(i_imm), .i_faddr(i_fa), .i_dest(i_dest),
		.i_file_data(i_fd), .i_pc_high_latch(i_pl), .o_pc(o_pc),
		.o_pc_load(o_pl), .o_acc(o_acc), .o_zero(o_z), .o_file_we(o_we),
		.o_file_addr(o_fa), .o_file_wdata(o_wd), .o_busy(o_busy),
		.o_done(o_done));
	initial forever #50 i_clock = ~i_clock;
	// Ceiling well above the forty or so cycles the run needs
	always @(posedge i_clock) if (++cyc == 500) begin
		n_errors++;
		tally_and_finish;
	end
	// ==========
	// Shared tasks
	task chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task run(input logic [2:0] op, input logic [10:0] k, input logic dd,
		input logic [7:0] f);
		@(posedge i_clock);
		{i_valid, i_op, i_imm, i_dest, i_fd, i_fa} <=
			{1'b1, op, k, dd, f, k[6:0]};
		@(posedge i_clock);
		i_valid <= 1'b0;
		#1;
	endtask
	// ==========
	// Scenarios
	task t_jump;
		run(3'h5, 11'h000, 1'b0, 8'h00);
		@(posedge i_clock);
		{i_valid, i_op, i_imm} <= {1'b1, 3'h1, 11'h7FF};
		@(posedge i_clock);
		// Literal OR offered while busy must be dropped
		{i_op, i_imm} <= {3'h2, 11'h0FF};
		#1 chk({o_pl, o_busy, o_pc}, 24'h7FFF);
		@(posedge i_clock);
		i_valid <= 1'b0;
		#1 chk({o_done, o_busy, o_pl, o_z, o_acc}, 24'h900);
	endtask
	task t_orlit;
		run(3'h2, 11'h000, 1'b0, 8'h00);
		chk({o_acc, o_z}, 24'h001);
		run(3'h2, 11'h7A5, 1'b0, 8'h00);
		chk({o_acc, o_z}, 24'h14A);
		run(3'h0, 11'h0FF, 1'b1, 8'h00);
		chk({o_done, o_we, o_pl, o_acc, o_z}, 24'h14A);
	endtask
	task t_increment_file;
		run(3'h3, 11'h015, 1'b1, 8'hFF);
		chk({o_acc, o_we, o_wd, o_z}, 24'h29601);
		chk(o_fa, 24'h15);
		run(3'h3, 11'h000, 1'b0, 8'h7F);
		chk({o_acc, o_z}, 24'h100);
	endtask
	task t_orwf;
		run(3'h4, 11'h000, 1'b0, 8'h03);
		chk({o_acc, o_z}, 24'h106);
		run(3'h4, 11'h06A, 1'b1, 8'h00);
		chk({o_acc, o_we, o_wd, o_z}, 24'h20F06);
		chk(o_fa, 24'h6A);
	endtask
	task t_move_file;
		run(3'h5, 11'h033, 1'b1, 8'h00);
		chk({o_acc, o_we, o_wd, o_z, o_done}, 24'h41C03);
		chk(o_fa, 24'h33);
		run(3'h5, 11'h000, 1'b0, 8'h5A);
		chk({o_acc, o_we, o_z}, 24'h168);
		chk(o_fa, 24'h33);
	endtask
	task t_reset;
		@(posedge i_clock);
		i_rst <= 1'b1;
		@(posedge i_clock);
		i_rst <= 1'b0;
		#1 chk({o_pc, o_acc, o_z}, 24'h000000);
		chk({o_fa, o_wd, o_done, o_pl, o_we, o_busy}, 24'h000000);
		run(3'h2, 11'h081, 1'b0, 8'h00);
		chk({o_acc, o_z, o_done}, 24'h205);
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge i_clock);
		i_rst <= 1'b0;
		t_jump;
		t_orlit;
		t_increment_file;
		t_orwf;
		t_move_file;
		t_reset;
		tally_and_finish;
	end
endmodule
